// ==== rtl/rail_on_off_control.sv ====
`timescale 1ns/1ps
// How it works
// - with fast-off cleared, the control pin going inactive ramps the rail down in a controlled sequence.
// - with fast-off set, the control pin going inactive stops power delivery at once.
// - command codes 0x00 immediate off, 0x40 soft off, 0x80 nominal on, 0x98 margin low, 0xA8 margin high.
// - with require-condition set, the rail stays off until the pin and/or the command call for it.
// - with honor-bus set, turn-on also needs the command to select an on state.
// - with honor-pin set, turn-on also needs the control pin to be active.
// - pin polarity set makes a high pin active, cleared makes a low pin active.
// - policy 0x1E honors both pin and command, active high, with soft pin turn-off.
// - policy 0x12 never turns the rail on and the command has no effect.
module rail_on_off_control (
	input  wire logic       clk,
	input  wire logic       reset,
	input  wire logic       control_pin,
	input  wire logic       policy_write,
	input  wire logic [7:0] policy_data,
	input  wire logic       command_write,
	input  wire logic [7:0] command_data,
	output logic      [7:0] turn_on_policy,
	output logic      [7:0] rail_command_state,
	output logic            rail_drive,
	output logic            soft_off_active,
	output logic            margin_low,
	output logic            margin_high
);

	typedef struct packed {
		logic                  pin_meta;
		logic                  pin_sync;
		logic [7:0]            policy;
		logic [7:0]            command;
		rail_pkg::rail_state_t state;
		logic                  drive;
		logic                  ramp;
		logic                  low;
		logic                  high;
	} ctrl_state_t;

	ctrl_state_t s;
	ctrl_state_t next_s;

	logic require_cond;
	logic honor_bus;
	logic honor_pin;
	logic fast_off;
	logic pin_active;
	logic cmd_on;
	logic on_request;
	logic immediate_off;
	logic timer_start;
	logic timer_done;

	// ==========================================
	// policy decode
	always_comb begin
		require_cond = s.policy[rail_pkg::POLICY_REQUIRE_BIT];
		honor_bus    = s.policy[rail_pkg::POLICY_HONOR_BUS_BIT];
		honor_pin    = s.policy[rail_pkg::POLICY_HONOR_PIN_BIT];
		fast_off     = s.policy[rail_pkg::POLICY_FAST_OFF_BIT];
		pin_active   = s.policy[rail_pkg::POLICY_POLARITY_BIT] ? s.pin_sync : !s.pin_sync;
		cmd_on       = (s.command == rail_pkg::CMD_ON_NOMINAL) ||
		               (s.command == rail_pkg::CMD_MARGIN_LOW) ||
		               (s.command == rail_pkg::CMD_MARGIN_HIGH);
		// require with neither source honored can never be satisfied
		on_request   = !require_cond ||
		               ((honor_bus || honor_pin) &&
		                (!honor_bus || cmd_on) &&
		                (!honor_pin || pin_active));
		// unknown command codes are treated like immediate off
		immediate_off = (require_cond && honor_pin && !pin_active && fast_off) ||
		                (require_cond && honor_bus && !cmd_on &&
		                 (s.command != rail_pkg::CMD_SOFT_OFF));
	end

	// ==========================================
	// next state
	always_comb begin
		next_s          = s;
		timer_start     = 1'b0;
		next_s.pin_meta = control_pin;
		next_s.pin_sync = s.pin_meta;
		if (policy_write) begin
			next_s.policy = policy_data;
		end
		if (command_write) begin
			next_s.command = command_data;
		end
		case (s.state)
			rail_pkg::RAIL_OFF: begin
				if (on_request) begin
					next_s.state = rail_pkg::RAIL_ON;
				end
			end
			rail_pkg::RAIL_ON: begin
				if (!on_request) begin
					if (immediate_off) begin
						next_s.state = rail_pkg::RAIL_OFF;
					end else begin
						next_s.state = rail_pkg::RAIL_RAMP;
						timer_start  = 1'b1;
					end
				end
			end
			rail_pkg::RAIL_RAMP: begin
				// a renewed request aborts the ramp rather than finishing it
				if (on_request) begin
					next_s.state = rail_pkg::RAIL_ON;
				end else if (immediate_off || timer_done) begin
					next_s.state = rail_pkg::RAIL_OFF;
				end
			end
			default: begin
				next_s.state = rail_pkg::RAIL_OFF;
			end
		endcase
		next_s.drive = (next_s.state != rail_pkg::RAIL_OFF);
		next_s.ramp  = (next_s.state == rail_pkg::RAIL_RAMP);
		next_s.low   = (next_s.state == rail_pkg::RAIL_ON) && (s.command == rail_pkg::CMD_MARGIN_LOW);
		next_s.high  = (next_s.state == rail_pkg::RAIL_ON) && (s.command == rail_pkg::CMD_MARGIN_HIGH);
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			s         <= '0;
			s.policy  <= rail_pkg::POLICY_RESET;
			s.command <= rail_pkg::COMMAND_RESET;
			s.state   <= rail_pkg::RAIL_OFF;
		end else begin
			s <= next_s;
		end
	end

	soft_off_timer u_timer (
		.clk   (clk),
		.reset (reset),
		.start (timer_start),
		.done  (timer_done)
	);

	assign turn_on_policy     = s.policy;
	assign rail_command_state = s.command;
	assign rail_drive         = s.drive;
	assign soft_off_active    = s.ramp;
	assign margin_low         = s.low;
	assign margin_high        = s.high;

	// ==========================================
	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	sequence seq_on_with_cmd;
		s.state == rail_pkg::RAIL_ON && require_cond && honor_pin && (!honor_bus || cmd_on);
	endsequence

	sequence seq_pin_inactive;
		!pin_active;
	endsequence

	a_pin_soft_off: assert property (seq_on_with_cmd and seq_pin_inactive and !fast_off
		|=> rail_drive && soft_off_active)
		else $error("soft pin off did not start a ramp");

	a_pin_fast_off: assert property (seq_on_with_cmd and seq_pin_inactive and fast_off
		|=> !rail_drive && !soft_off_active)
		else $error("fast pin off left the rail powered");

	a_margin_low_cmd: assert property (rail_drive && !soft_off_active &&
		$past(s.command) == rail_pkg::CMD_MARGIN_LOW |-> margin_low && !margin_high)
		else $error("margin low not shown for command 0x98");

	a_bus_gate_off: assert property (s.state == rail_pkg::RAIL_OFF && require_cond && honor_bus && !cmd_on
		|=> !rail_drive)
		else $error("rail turned on without an on command");

	a_pin_gate_off: assert property (s.state == rail_pkg::RAIL_OFF && require_cond && honor_pin && !pin_active
		|=> !rail_drive)
		else $error("rail turned on with pin inactive");

	a_low_polarity: assert property (s.state == rail_pkg::RAIL_OFF && require_cond && honor_pin && !honor_bus &&
		!s.policy[rail_pkg::POLICY_POLARITY_BIT] && !s.pin_sync |=> rail_drive)
		else $error("low pin not active under low polarity");

	a_policy_both_on: assert property (s.policy == rail_pkg::POLICY_BOTH_SOFT && s.pin_sync &&
		s.command == rail_pkg::CMD_ON_NOMINAL && s.state == rail_pkg::RAIL_OFF |=> rail_drive)
		else $error("policy 0x1E with pin and command did not turn on");

	a_never_on_policy: assert property (s.policy == rail_pkg::POLICY_NEVER_ON && !rail_drive
		|=> !rail_drive)
		else $error("policy 0x12 powered the rail");

	a_free_turn_on: assert property (!require_cond |=> rail_drive && !soft_off_active)
		else $error("rail not on with require cleared");

	a_ramp_bounded: assert property ($rose(soft_off_active) |-> ##[1:130] !soft_off_active)
		else $error("soft off ramp did not end");

endmodule : rail_on_off_control

// ==== rtl/rail_pkg.sv ====
package rail_pkg;

	// ==========================================
	// clock and timing
	localparam int CLK_PERIOD_NS    = 8;
	localparam int SOFT_OFF_TIME_NS = 1000;
	localparam int SOFT_OFF_CYCLES_INT = (SOFT_OFF_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TIMER_WIDTH      = 8;
	localparam logic [TIMER_WIDTH-1:0] SOFT_OFF_CYCLES = TIMER_WIDTH'(SOFT_OFF_CYCLES_INT);

	// ==========================================
	// turn_on_policy fields
	localparam int POLICY_FAST_OFF_BIT  = 0;
	localparam int POLICY_POLARITY_BIT  = 1;
	localparam int POLICY_HONOR_PIN_BIT = 2;
	localparam int POLICY_HONOR_BUS_BIT = 3;
	localparam int POLICY_REQUIRE_BIT   = 4;

	localparam logic [7:0] POLICY_BOTH_SOFT = 8'h1E;
	localparam logic [7:0] POLICY_NEVER_ON  = 8'h12;
	localparam logic [7:0] POLICY_RESET     = POLICY_BOTH_SOFT;

	// ==========================================
	// rail_command_state codes
	localparam logic [7:0] CMD_IMMEDIATE_OFF = 8'h00;
	localparam logic [7:0] CMD_SOFT_OFF      = 8'h40;
	localparam logic [7:0] CMD_ON_NOMINAL    = 8'h80;
	localparam logic [7:0] CMD_MARGIN_LOW    = 8'h98;
	localparam logic [7:0] CMD_MARGIN_HIGH   = 8'hA8;
	localparam logic [7:0] COMMAND_RESET     = CMD_IMMEDIATE_OFF;

	// ==========================================
	// rail states, gray along off -> on -> ramp
	typedef enum logic [1:0] {
		RAIL_OFF  = 2'h0,
		RAIL_ON   = 2'h1,
		RAIL_RAMP = 2'h3
	} rail_state_t;

endpackage : rail_pkg

// ==== rtl/soft_off_timer.sv ====
`timescale 1ns/1ps
module soft_off_timer (
	input  wire logic clk,
	input  wire logic reset,
	input  wire logic start,
	output logic      done
);

	typedef struct packed {
		logic [rail_pkg::TIMER_WIDTH-1:0] count;
		logic                             done;
	} timer_state_t;

	timer_state_t s;
	timer_state_t next_s;

	always_comb begin
		next_s      = s;
		next_s.done = 1'b0;
		if (start) begin
			next_s.count = rail_pkg::SOFT_OFF_CYCLES;
		end else if (s.count != '0) begin
			next_s.count = s.count - 1'b1;
			next_s.done  = (s.count == rail_pkg::TIMER_WIDTH'(1));
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign done = s.done;

endmodule : soft_off_timer

// ==== verification/rail_host_model.sv ====
`timescale 1ns/1ps
module rail_host_model (
	input  wire logic       clk,
	output logic            control_pin,
	output logic            policy_write,
	output logic      [7:0] policy_data,
	output logic            command_write,
	output logic      [7:0] command_data
);
	initial begin
		control_pin   = 1'b0;
		policy_write  = 1'b0;
		policy_data   = 8'h00;
		command_write = 1'b0;
		command_data  = 8'h00;
	end

	// ==========================================
	// host writes, one strobe cycle each
	// stale data is inverted so nothing leans on a held value
	task automatic write_policy(input logic [7:0] v);
		@(posedge clk);
		policy_write <= 1'b1;
		policy_data  <= v;
		@(posedge clk);
		policy_write <= 1'b0;
		policy_data  <= ~v;
	endtask : write_policy

	task automatic write_command(input logic [7:0] v);
		@(posedge clk);
		command_write <= 1'b1;
		command_data  <= v;
		@(posedge clk);
		command_write <= 1'b0;
		command_data  <= ~v;
	endtask : write_command

	task automatic set_pin(input logic v);
		@(posedge clk);
		control_pin <= v;
	endtask : set_pin
endmodule : rail_host_model

// ==== verification/rail_on_off_control_bench.sv ====
`timescale 1ns/1ps
module rail_on_off_control_bench;
	logic       clk   = 1'b0;
	logic       reset = 1'b1;
	logic       control_pin;
	logic       policy_write;
	logic [7:0] policy_data;
	logic       command_write;
	logic [7:0] command_data;
	logic [7:0] turn_on_policy;
	logic [7:0] rail_command_state;
	logic       rail_drive;
	logic       soft_off_active;
	logic       margin_low;
	logic       margin_high;
	int         n_errors        = 0;
	int         samples_checked = 0;
	int         cycles          = 0;

	always #4 clk = ~clk;

	rail_host_model i_host (
		.clk           (clk),
		.control_pin   (control_pin),
		.policy_write  (policy_write),
		.policy_data   (policy_data),
		.command_write (command_write),
		.command_data  (command_data)
	);

	rail_on_off_control i_dut (
		.clk                (clk),
		.reset              (reset),
		.control_pin        (control_pin),
		.policy_write       (policy_write),
		.policy_data        (policy_data),
		.command_write      (command_write),
		.command_data       (command_data),
		.turn_on_policy     (turn_on_policy),
		.rail_command_state (rail_command_state),
		.rail_drive         (rail_drive),
		.soft_off_active    (soft_off_active),
		.margin_low         (margin_low),
		.margin_high        (margin_high)
	);

	// ==========================================
	// helpers
	task automatic stop_test();
		$display("counts: %0d mismatches in %0d checks", n_errors, samples_checked);
		if (n_errors == 0 && samples_checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : stop_test

	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			n_errors++;
			stop_test();
		end
	end

	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		samples_checked++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	// outputs packed as drive, soft, low, high
	function automatic logic [7:0] outs();
		return {4'h0, rail_drive, soft_off_active, margin_low, margin_high};
	endfunction : outs

	task automatic settle(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : settle

	// ramp must run its full length, not end early or hang
	task automatic ramp_down();
		int   n;
		logic len_ok;
		for (n = 0; n < 200 && rail_drive !== 1'b0; n++) settle(1);
		// entry is seen zero or one edge late, so allow one cycle either way
		len_ok = (n >= rail_pkg::SOFT_OFF_CYCLES_INT - 1) && (n <= rail_pkg::SOFT_OFF_CYCLES_INT + 1);
		chk("ramp length ok", 8'h01, {7'h00, len_ok});
		chk("outputs after ramp", 8'h00, outs());
	endtask : ramp_down

	// ==========================================
	// scenarios
	task automatic t_both();
		i_host.write_command(8'h80);
		settle(2);
		chk("outputs pin inactive", 8'h00, outs());
		i_host.set_pin(1'b1);
		settle(3);
		chk("outputs on", 8'h08, outs());
		i_host.write_command(8'h98);
		settle(2);
		chk("outputs margin low", 8'h0A, outs());
		chk("command readback", 8'h98, rail_command_state);
		i_host.write_command(8'hA8);
		settle(2);
		chk("outputs margin high", 8'h09, outs());
		i_host.write_command(8'h00);
		settle(2);
		chk("outputs immediate off", 8'h00, outs());
		i_host.write_command(8'h80);
		i_host.write_command(8'h40);
		settle(2);
		chk("outputs soft off", 8'h0C, outs());
		ramp_down();
		$display("test done: pin and command");
	endtask : t_both

	task automatic t_pin_off();
		i_host.write_command(8'h80);
		settle(2);
		chk("outputs on again", 8'h08, outs());
		i_host.set_pin(1'b0);
		settle(3);
		chk("outputs pin soft off", 8'h0C, outs());
		ramp_down();
		i_host.write_policy(8'h1F);
		i_host.set_pin(1'b1);
		settle(3);
		chk("outputs fast policy on", 8'h08, outs());
		i_host.set_pin(1'b0);
		settle(3);
		chk("outputs fast off", 8'h00, outs());
		$display("test done: pin off modes");
	endtask : t_pin_off

	task automatic t_polarity();
		i_host.write_policy(8'h1C);
		settle(2);
		chk("outputs active low on", 8'h08, outs());
		i_host.set_pin(1'b1);
		settle(3);
		chk("outputs active low off", 8'h0C, outs());
		ramp_down();
		// pin only, active low: the command must not matter
		i_host.write_policy(8'h14);
		i_host.write_command(8'h00);
		settle(2);
		chk("outputs pin only inactive", 8'h00, outs());
		i_host.set_pin(1'b0);
		settle(3);
		chk("outputs pin only on", 8'h08, outs());
		i_host.write_policy(8'h15);
		i_host.set_pin(1'b1);
		settle(3);
		chk("outputs pin only fast off", 8'h00, outs());
		$display("test done: polarity");
	endtask : t_polarity

	task automatic t_never_free();
		i_host.write_policy(8'h12);
		i_host.write_command(8'h80);
		settle(1);
		chk("policy readback", 8'h12, turn_on_policy);
		settle(20);
		chk("outputs never on", 8'h00, outs());
		i_host.write_command(8'h00);
		i_host.set_pin(1'b0);
		// honor bits set but require cleared: pin and command both say off
		i_host.write_policy(8'h0E);
		settle(2);
		chk("outputs free run", 8'h08, outs());
		$display("test done: never and free");
	endtask : t_never_free

	task automatic t_reset_mid();
		@(posedge clk);
		reset <= 1'b1;
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		settle(1);
		chk("policy after reset", 8'h1E, turn_on_policy);
		chk("command after reset", 8'h00, rail_command_state);
		chk("outputs after reset", 8'h00, outs());
		$display("test done: reset in run");
	endtask : t_reset_mid

	initial begin
		repeat (16) @(posedge clk);
		reset <= 1'b0;
		settle(1);
		chk("policy reset", 8'h1E, turn_on_policy);
		chk("command reset", 8'h00, rail_command_state);
		chk("outputs reset", 8'h00, outs());
		$display("test done: reset values");
		t_both();
		t_pin_off();
		t_polarity();
		t_never_free();
		t_reset_mid();
		stop_test();
	end
endmodule : rail_on_off_control_bench
